// ---- hw/cfd_config_fuse.sv ----
// What this block does
// - top bit of clock byte enables oscillator switchover
// - bit six of clock byte enables the fail-safe clock monitor
// - 1001 internal osc with clock out on pin a; 1000 both pins port
// - 11xx, 101x, 0011, 0111 external RC; clock out except 0111
// - 0110 high-speed crystal with x4 PLL; 0010 without PLL
// - 0101 external clock, pin a port; 0100 external clock, clock out
// - 0001 standard crystal; 0000 low-power crystal
// - brown-out level field: 11 lowest up to 00 highest trip
// - brown-out mode 11: always on, software enable ignored
// - mode 10: on while running, off in sleep, software ignored
// - mode 01 software controlled, mode 00 brown-out fully off
// - watchdog postscale ratio is two to the power of the code
// - watchdog force bit set: watchdog always runs
// - otherwise software watchdog enable turns watchdog on or off
// - reset pin bit: one is external reset, zero general input
// - bit two of pin byte selects low-power secondary oscillator
// - routing bit one puts capture unit two on port C pin
// - debug bit zero enables debugger and dedicates two pins
// - extended instruction bit one enables extension and indexing
// - stack-fault bit one lets stack full or underflow reset
// - read-only 11-bit part code and 5-bit revision in two bytes
// - unimplemented bits of every configuration byte read zero
// - unprogrammed bits read one; space reached by table read, table write only clears code-protect bit
module cfd_config_fuse
    import cfd_pkg::*;
#(
    parameter int ADDR_W = CFD_ADDR_W,
    parameter logic [10:0] PART_CODE = 11'h2A6, // arbitrary value
    parameter logic [4:0] REV_CODE = 5'h03 // arbitrary value
)
(
    input wire logic core_clk, // system clock
    input wire logic nrst, // async reset, low active
    input wire cfd_pkg::cfd_image_t nv_image, // stored fuse bytes
    input wire logic sleep_mode, // core is in sleep
    input wire logic sw_brownout_en, // software brown-out enable
    input wire logic sw_watchdog_en, // software watchdog enable
    input wire logic tbl_rd_en, // table read strobe
    input wire logic tbl_wr_en, // table write strobe
    input wire logic [ADDR_W-1:0] tbl_addr, // table address
    input wire logic [7:0] tbl_wr_data, // table write data
    output logic [7:0] tbl_rd_data, // table read data
    output logic tbl_rd_valid, // read data valid
    output logic cfg_loaded, // bytes latched, block running
    output cfd_pkg::cfd_ctrl_t ctrl // decoded device settings
);
    import cfd_pkg::*;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (ADDR_W != CFD_ADDR_W)
    begin : g_bad_width
        $error("cfd_config_fuse: ADDR_W must be 22");
    end

    // ----------------------------------------
    // decoding helpers
    // ----------------------------------------
    function automatic logic [7:0] cfd_mask(
        input logic [ADDR_W-1:0] a
    );
        case (a)
            CFD_ADDR_CLK_SRC: cfd_mask = CFD_MASK_CLK_SRC;
            CFD_ADDR_BOR_POWERUP_DELAY_TIMER: cfd_mask = CFD_MASK_BOR_POWERUP_DELAY_TIMER;
            CFD_ADDR_WDT: cfd_mask = CFD_MASK_WDT;
            CFD_ADDR_PIN_TMR: cfd_mask = CFD_MASK_PIN_TMR;
            CFD_ADDR_DBG: cfd_mask = CFD_MASK_DBG;
            CFD_ADDR_CP: cfd_mask = CFD_MASK_CP;
            CFD_ADDR_ID_LOW: cfd_mask = 8'hFF;
            CFD_ADDR_ID_HIGH: cfd_mask = 8'hFF;
            default: cfd_mask = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] cfd_read(
        input cfd_image_t img,
        input logic [ADDR_W-1:0] a
    );
        logic [7:0] raw;
        case (a)
            CFD_ADDR_CLK_SRC: raw = img.clk_src;
            CFD_ADDR_BOR_POWERUP_DELAY_TIMER: raw = img.bor_powerup_delay_timer;
            CFD_ADDR_WDT: raw = img.wdt;
            CFD_ADDR_PIN_TMR: raw = img.pin_tmr;
            CFD_ADDR_DBG: raw = img.dbg;
            CFD_ADDR_CP: raw = img.cp;
            CFD_ADDR_ID_LOW: raw = {PART_CODE[2:0], REV_CODE};
            CFD_ADDR_ID_HIGH: raw = PART_CODE[10:3];
            default: raw = 8'h00;
        endcase
        cfd_read = raw & cfd_mask(a);
    endfunction

    function automatic cfd_osc_t cfd_osc(input logic [3:0] sel);
        cfd_osc_t o;
        o = '{CFD_OSC_LP, 1'b0, 1'b0, 1'b0, 1'b0};
        casez (sel)
            4'b11??, 4'b101?, 4'b0011:
            begin
                o.source = CFD_OSC_ERC;
                o.clock_out_en = 1'b1;
            end
            4'b0111:
            begin
                o.source = CFD_OSC_ERC;
                o.osc_pin_a_port = 1'b1;
            end
            4'b1001:
            begin
                o.source = CFD_OSC_INT;
                o.clock_out_en = 1'b1;
                o.osc_pin_b_port = 1'b1;
            end
            4'b1000:
            begin
                o.source = CFD_OSC_INT;
                o.osc_pin_a_port = 1'b1;
                o.osc_pin_b_port = 1'b1;
            end
            4'b0110:
            begin
                o.source = CFD_OSC_HSPLL;
                o.pll_en = 1'b1;
            end
            4'b0101:
            begin
                o.source = CFD_OSC_EC;
                o.osc_pin_a_port = 1'b1;
            end
            4'b0100:
            begin
                o.source = CFD_OSC_EC;
                o.clock_out_en = 1'b1;
            end
            4'b0010: o.source = CFD_OSC_HS;
            4'b0001: o.source = CFD_OSC_XT;
            default: o.source = CFD_OSC_LP;
        endcase
        return o;
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        cfd_state_t state;
        cfd_image_t img;
        cfd_ctrl_t ctrl;
        logic [7:0] rd_data;
        logic rd_valid;
        logic loaded;
    } cfd_regs_t;

    localparam cfd_image_t IMG_RST = '{
        CFD_RST_CLK_SRC, CFD_RST_BOR_POWERUP_DELAY_TIMER, CFD_RST_WDT,
        CFD_RST_PIN_TMR, CFD_RST_DBG, CFD_RST_CP
    };
    localparam cfd_image_t IMG_MASK = '{
        CFD_MASK_CLK_SRC, CFD_MASK_BOR_POWERUP_DELAY_TIMER, CFD_MASK_WDT,
        CFD_MASK_PIN_TMR, CFD_MASK_DBG, CFD_MASK_CP
    };

    cfd_regs_t st_q;
    cfd_regs_t st_d;
    logic [1:0] bor_mode;

    assign bor_mode = st_q.img.bor_powerup_delay_timer[2:1];

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb
    begin
        st_d = st_q;
        st_d.rd_valid = 1'b0;
        case (st_q.state)
            CFD_ST_LOAD:
            begin
                // catch the stored bytes once after reset release
                st_d.img = nv_image & IMG_MASK;
                st_d.loaded = 1'b1;
                st_d.state = CFD_ST_RUN;
            end
            CFD_ST_RUN:
            begin
                if (tbl_rd_en)
                begin
                    st_d.rd_data = cfd_read(st_q.img, tbl_addr);
                    st_d.rd_valid = 1'b1;
                end
                if (tbl_wr_en && tbl_addr == CFD_ADDR_CP)
                begin
                    st_d.img.cp[CFD_BIT_CP_N] =
                        st_q.img.cp[CFD_BIT_CP_N] &
                        tbl_wr_data[CFD_BIT_CP_N];
                end
                st_d.ctrl.osc_switchover_en =
                    st_q.img.clk_src[CFD_BIT_SWITCHOVER];
                st_d.ctrl.clock_monitor_en =
                    st_q.img.clk_src[CFD_BIT_CLK_MON];
                st_d.ctrl.osc = cfd_osc(st_q.img.clk_src[3:0]);
                st_d.ctrl.brownout_level =
                    st_q.img.bor_powerup_delay_timer[4:3];
                case (bor_mode)
                    CFD_BOR_HW: st_d.ctrl.brownout_active = 1'b1;
                    CFD_BOR_HW_NOSLEEP:
                        st_d.ctrl.brownout_active = !sleep_mode;
                    CFD_BOR_SW:
                        st_d.ctrl.brownout_active = sw_brownout_en;
                    default: st_d.ctrl.brownout_active = 1'b0;
                endcase
                st_d.ctrl.sw_brownout_used = bor_mode == CFD_BOR_SW;
                st_d.ctrl.powerup_timer_en =
                    !st_q.img.bor_powerup_delay_timer[CFD_BIT_POWERUP_DELAY_TIMER_OFF_N];
                st_d.ctrl.watchdog_postscale = st_q.img.wdt[4:1];
                st_d.ctrl.watchdog_ratio =
                    CFD_RATIO_ONE << st_q.img.wdt[4:1];
                st_d.ctrl.watchdog_run =
                    st_q.img.wdt[CFD_BIT_WDT_FORCE] ||
                    sw_watchdog_en;
                st_d.ctrl.sw_watchdog_used =
                    !st_q.img.wdt[CFD_BIT_WDT_FORCE];
                st_d.ctrl.ext_reset_en =
                    st_q.img.pin_tmr[CFD_BIT_RESET_PIN];
                st_d.ctrl.shared_pin_input_en =
                    !st_q.img.pin_tmr[CFD_BIT_RESET_PIN];
                st_d.ctrl.low_power_sec_osc =
                    st_q.img.pin_tmr[CFD_BIT_LP_SEC_OSC];
                st_d.ctrl.capture2_on_port_c =
                    st_q.img.pin_tmr[CFD_BIT_CAP2_ROUTE];
                st_d.ctrl.debugger_en =
                    !st_q.img.dbg[CFD_BIT_DEBUG_N];
                st_d.ctrl.extended_isa_en =
                    st_q.img.dbg[CFD_BIT_EXT_ISA];
                st_d.ctrl.stack_fault_reset_en =
                    st_q.img.dbg[CFD_BIT_STACK_RST];
                st_d.ctrl.code_protected =
                    !st_q.img.cp[CFD_BIT_CP_N];
            end
            default:
            begin
                st_d.state = CFD_ST_LOAD;
            end
        endcase
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st_q <= '{
                state: CFD_ST_LOAD,
                img: IMG_RST,
                ctrl: '0,
                rd_data: 8'h00,
                rd_valid: 1'b0,
                loaded: 1'b0
            };
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign tbl_rd_data = st_q.rd_data;
    assign tbl_rd_valid = st_q.rd_valid;
    assign cfg_loaded = st_q.loaded;
    assign ctrl = st_q.ctrl;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    logic run;
    assign run = st_q.state == CFD_ST_RUN;

    chk_read_latency: assert property (
        run && tbl_rd_en |=> tbl_rd_valid
            && tbl_rd_data == cfd_read($past(st_q.img), $past(tbl_addr))
    ) else $error("table read answer wrong or late");

    chk_unimpl_zero: assert property (
        tbl_rd_valid |->
            (tbl_rd_data & ~cfd_mask($past(tbl_addr))) == 8'h00
    ) else $error("unimplemented bit read as one");

    chk_osc_pll: assert property (
        run && st_q.img.clk_src[3:0] == 4'h6 |=>
            ctrl.osc.pll_en && ctrl.osc.source == CFD_OSC_HSPLL
    ) else $error("pll mode not decoded");

    chk_osc_int_pins: assert property (
        run && st_q.img.clk_src[3:0] == 4'h8 |=>
            ctrl.osc.osc_pin_a_port && ctrl.osc.osc_pin_b_port
            && !ctrl.osc.clock_out_en
    ) else $error("internal osc pins not freed");

    chk_bor_hw_on: assert property (
        run && bor_mode == CFD_BOR_HW ##1 run |-> ctrl.brownout_active
    ) else $error("hardware brown-out not forced on");

    chk_bor_sleep: assert property (
        run && bor_mode == CFD_BOR_HW_NOSLEEP |=>
            ctrl.brownout_active == !$past(sleep_mode)
    ) else $error("brown-out not dropped in sleep");

    chk_wdt_force: assert property (
        run && st_q.img.wdt[CFD_BIT_WDT_FORCE] && !sw_watchdog_en
            |=> ctrl.watchdog_run
    ) else $error("forced watchdog not running");

    chk_wdt_sw: assert property (
        run && !st_q.img.wdt[CFD_BIT_WDT_FORCE] |=>
            ctrl.watchdog_run == $past(sw_watchdog_en)
    ) else $error("software watchdog enable not followed");

    chk_ratio_pow2: assert property (
        run |=> ctrl.watchdog_ratio ==
            (CFD_RATIO_ONE << $past(st_q.img.wdt[4:1]))
    ) else $error("watchdog ratio wrong");

    chk_cp_sticky: assert property (
        !st_q.img.cp[CFD_BIT_CP_N] && run |=>
            !st_q.img.cp[CFD_BIT_CP_N]
    ) else $error("code protect set again");

    chk_load_hold: assert property (
        run |=> run && $stable(st_q.img.clk_src)
            && $stable(st_q.img.wdt)
    ) else $error("latched configuration changed");

    cov_cp_clear: cover property (
        run && tbl_wr_en && tbl_addr == CFD_ADDR_CP
            && !tbl_wr_data[CFD_BIT_CP_N]
    );
    cov_id_read: cover property (
        run && tbl_rd_en && tbl_addr == CFD_ADDR_ID_HIGH
    );
    cov_bor_sleep: cover property (
        run && bor_mode == CFD_BOR_HW_NOSLEEP && sleep_mode
    );

endmodule

// ---- hw/cfd_pkg.sv ----
package cfd_pkg;

    // ----------------------------------------
    // table-read address map
    // ----------------------------------------
    localparam int CFD_ADDR_W = 22;
    localparam logic [21:0] CFD_ADDR_CLK_SRC = 22'h300001;
    localparam logic [21:0] CFD_ADDR_BOR_POWERUP_DELAY_TIMER = 22'h300002;
    localparam logic [21:0] CFD_ADDR_WDT = 22'h300003;
    localparam logic [21:0] CFD_ADDR_PIN_TMR = 22'h300005;
    localparam logic [21:0] CFD_ADDR_DBG = 22'h300006;
    localparam logic [21:0] CFD_ADDR_CP = 22'h300008;
    localparam logic [21:0] CFD_ADDR_ID_LOW = 22'h3FFFFE;
    localparam logic [21:0] CFD_ADDR_ID_HIGH = 22'h3FFFFF;

    // ----------------------------------------
    // implemented bits and unprogrammed values
    // ----------------------------------------
    localparam logic [7:0] CFD_MASK_CLK_SRC = 8'hCF;
    localparam logic [7:0] CFD_MASK_BOR_POWERUP_DELAY_TIMER = 8'h1F;
    localparam logic [7:0] CFD_MASK_WDT = 8'h1F;
    localparam logic [7:0] CFD_MASK_PIN_TMR = 8'h85;
    localparam logic [7:0] CFD_MASK_DBG = 8'hC1;
    localparam logic [7:0] CFD_MASK_CP = 8'h01;
    localparam logic [7:0] CFD_RST_CLK_SRC = 8'h07;
    localparam logic [7:0] CFD_RST_BOR_POWERUP_DELAY_TIMER = 8'h1F;
    localparam logic [7:0] CFD_RST_WDT = 8'h1F;
    localparam logic [7:0] CFD_RST_PIN_TMR = 8'h81;
    localparam logic [7:0] CFD_RST_DBG = 8'h81;
    localparam logic [7:0] CFD_RST_CP = 8'h01;

    // ----------------------------------------
    // field positions and codes
    // ----------------------------------------
    localparam int CFD_BIT_SWITCHOVER = 7;
    localparam int CFD_BIT_CLK_MON = 6;
    localparam int CFD_BIT_POWERUP_DELAY_TIMER_OFF_N = 0;
    localparam int CFD_BIT_WDT_FORCE = 0;
    localparam int CFD_BIT_RESET_PIN = 7;
    localparam int CFD_BIT_LP_SEC_OSC = 2;
    localparam int CFD_BIT_CAP2_ROUTE = 0;
    localparam int CFD_BIT_DEBUG_N = 7;
    localparam int CFD_BIT_EXT_ISA = 6;
    localparam int CFD_BIT_STACK_RST = 0;
    localparam int CFD_BIT_CP_N = 0;
    localparam logic [1:0] CFD_BOR_HW = 2'h3;
    localparam logic [1:0] CFD_BOR_HW_NOSLEEP = 2'h2;
    localparam logic [1:0] CFD_BOR_SW = 2'h1;
    localparam logic [1:0] CFD_BOR_OFF = 2'h0;
    localparam logic [15:0] CFD_RATIO_ONE = 16'h0001;

    typedef enum logic [1:0] {
        CFD_ST_LOAD = 2'b01,
        CFD_ST_RUN = 2'b10
    } cfd_state_t;

    typedef enum logic [2:0] {
        CFD_OSC_LP = 3'h0,
        CFD_OSC_XT = 3'h1,
        CFD_OSC_HS = 3'h2,
        CFD_OSC_HSPLL = 3'h3,
        CFD_OSC_EC = 3'h4,
        CFD_OSC_ERC = 3'h5,
        CFD_OSC_INT = 3'h6
    } cfd_osc_src_t;

    typedef struct packed {
        logic [7:0] clk_src;
        logic [7:0] bor_powerup_delay_timer;
        logic [7:0] wdt;
        logic [7:0] pin_tmr;
        logic [7:0] dbg;
        logic [7:0] cp;
    } cfd_image_t;

    typedef struct packed {
        cfd_osc_src_t source;
        logic pll_en;
        logic clock_out_en;
        logic osc_pin_a_port;
        logic osc_pin_b_port;
    } cfd_osc_t;

    typedef struct packed {
        logic osc_switchover_en;
        logic clock_monitor_en;
        cfd_osc_t osc;
        logic [1:0] brownout_level;
        logic brownout_active;
        logic sw_brownout_used;
        logic powerup_timer_en;
        logic [3:0] watchdog_postscale;
        logic [15:0] watchdog_ratio;
        logic watchdog_run;
        logic sw_watchdog_used;
        logic ext_reset_en;
        logic shared_pin_input_en;
        logic low_power_sec_osc;
        logic capture2_on_port_c;
        logic debugger_en;
        logic extended_isa_en;
        logic stack_fault_reset_en;
        logic code_protected;
    } cfd_ctrl_t;

endpackage

// ---- bench/cfd_config_fuse_tb_top.sv ----
`define cfd_chk(got, exp) \
    begin \
        n_checks++; \
        if ((got) !== (exp)) \
        begin \
            n_fail++; \
            $display("mismatch at %0t: got %0h expected %0h", \
                $time, (got), (exp)); \
        end \
    end

module cfd_config_fuse_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import cfd_pkg::*;

    localparam logic [10:0] TB_PART = 11'h5C3; // arbitrary value
    localparam logic [4:0] TB_REV = 5'h0A; // arbitrary value

    logic core_clk = 1'b0;
    logic nrst = 1'b0;
    cfd_image_t nv_image = '1;
    logic sleep_mode = 1'b0;
    logic sw_brownout_en = 1'b0;
    logic sw_watchdog_en = 1'b0;
    logic tbl_rd_en = 1'b0;
    logic tbl_wr_en = 1'b0;
    logic [21:0] tbl_addr = '0;
    logic [7:0] tbl_wr_data = '0;
    logic [7:0] tbl_rd_data;
    logic tbl_rd_valid;
    logic cfg_loaded;
    cfd_ctrl_t ctrl;
    int n_fail = 0;
    int n_checks = 0;

    logic [21:0] addr_tab [6] = '{CFD_ADDR_CLK_SRC, CFD_ADDR_BOR_POWERUP_DELAY_TIMER,
        CFD_ADDR_WDT, CFD_ADDR_PIN_TMR, CFD_ADDR_DBG, CFD_ADDR_CP};
    logic [7:0] mask_tab [6] = '{8'hCF, 8'h1F, 8'h1F, 8'h85, 8'hC1, 8'h01};

    always #5 core_clk = ~core_clk;

    cfd_config_fuse #(.PART_CODE(TB_PART), .REV_CODE(TB_REV)) dut (
        .core_clk(core_clk),
        .nrst(nrst),
        .nv_image(nv_image),
        .sleep_mode(sleep_mode),
        .sw_brownout_en(sw_brownout_en),
        .sw_watchdog_en(sw_watchdog_en),
        .tbl_rd_en(tbl_rd_en),
        .tbl_wr_en(tbl_wr_en),
        .tbl_addr(tbl_addr),
        .tbl_wr_data(tbl_wr_data),
        .tbl_rd_data(tbl_rd_data),
        .tbl_rd_valid(tbl_rd_valid),
        .cfg_loaded(cfg_loaded),
        .ctrl(ctrl)
    );

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic close_out();
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic rd(input logic [21:0] a, input logic [7:0] e);
        @(posedge core_clk);
        tbl_rd_en <= 1'b1;
        tbl_addr <= a;
        @(posedge core_clk);
        tbl_rd_en <= 1'b0;
        #1;
        `cfd_chk(tbl_rd_valid, 1'b1)
        `cfd_chk(tbl_rd_data, e)
    endtask

    task automatic wr(input logic [21:0] a, input logic [7:0] d);
        @(posedge core_clk);
        tbl_wr_en <= 1'b1;
        tbl_addr <= a;
        tbl_wr_data <= d;
        @(posedge core_clk);
        tbl_wr_en <= 1'b0;
    endtask

    // image latched at the first edge after reset release, then scrambled to prove it is held
    task automatic load(input cfd_image_t img);
        @(posedge core_clk);
        nrst <= 1'b0;
        nv_image <= img;
        sleep_mode <= 1'b0;
        sw_brownout_en <= 1'b0;
        sw_watchdog_en <= 1'b0;
        @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        nv_image <= ~img;
        tick(1);
    endtask

    // ----------------------------------------
    // expected decode
    // ----------------------------------------
    function automatic cfd_osc_t osc_exp(input logic [3:0] c);
        cfd_osc_t o;
        o = '0;
        if (c[3:2] == 2'b11 || c[3:1] == 3'b101 || c == 4'h3 || c == 4'h7)
            o.source = CFD_OSC_ERC;
        else if (c[3:1] == 3'b100)
            o.source = CFD_OSC_INT;
        else if (c == 4'h4 || c == 4'h5)
            o.source = CFD_OSC_EC;
        else if (c == 4'h6)
            o.source = CFD_OSC_HSPLL;
        else if (c == 4'h2)
            o.source = CFD_OSC_HS;
        else if (c == 4'h1)
            o.source = CFD_OSC_XT;
        else
            o.source = CFD_OSC_LP;
        o.pll_en = (c == 4'h6);
        o.clock_out_en = (o.source == CFD_OSC_ERC && c != 4'h7)
            || c == 4'h9 || c == 4'h4;
        o.osc_pin_a_port = (c == 4'h8 || c == 4'h7 || c == 4'h5);
        o.osc_pin_b_port = (c[3:1] == 3'b100);
        return o;
    endfunction

    task automatic check_ctrl(input logic [3:0] i, input logic s,
        input logic b);
        logic act;
        act = (i[1:0] == 2'h3) || (i[1:0] == 2'h2 && !s)
            || (i[1:0] == 2'h1 && b);
        `cfd_chk(ctrl.osc_switchover_en, i[1])
        `cfd_chk(ctrl.clock_monitor_en, i[0])
        `cfd_chk(ctrl.osc, osc_exp(i))
        `cfd_chk(ctrl.brownout_level, i[3:2])
        `cfd_chk(ctrl.brownout_active, act)
        `cfd_chk(ctrl.sw_brownout_used, i[1:0] == 2'h1)
        `cfd_chk(ctrl.powerup_timer_en, ~i[2])
        `cfd_chk(ctrl.watchdog_postscale, i)
        `cfd_chk(ctrl.watchdog_ratio, 16'h0001 << i)
        `cfd_chk(ctrl.watchdog_run, i[0] | b)
        `cfd_chk(ctrl.sw_watchdog_used, ~i[0])
        `cfd_chk(ctrl.ext_reset_en, i[0])
        `cfd_chk(ctrl.shared_pin_input_en, ~i[0])
        `cfd_chk(ctrl.low_power_sec_osc, i[1])
        `cfd_chk(ctrl.capture2_on_port_c, i[2])
        `cfd_chk(ctrl.debugger_en, ~i[0])
        `cfd_chk(ctrl.extended_isa_en, i[1])
        `cfd_chk(ctrl.stack_fault_reset_en, i[3])
        `cfd_chk(ctrl.code_protected, ~i[1])
    endtask

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        cfd_image_t img;
        logic [3:0] i;
        repeat (5) @(posedge core_clk);
        #1;
        `cfd_chk(ctrl, cfd_ctrl_t'('0))
        `cfd_chk(cfg_loaded, 1'b0)
        @(posedge core_clk);
        nrst <= 1'b1;
        tbl_rd_en <= 1'b1;
        tbl_addr <= CFD_ADDR_CLK_SRC;
        @(posedge core_clk);
        tbl_rd_en <= 1'b0;
        tick(1);
        `cfd_chk(cfg_loaded, 1'b1)
        `cfd_chk(tbl_rd_valid, 1'b0)
        for (int k = 0; k < 6; k++)
            rd(addr_tab[k], mask_tab[k]);
        rd(CFD_ADDR_ID_LOW, {TB_PART[2:0], TB_REV});
        rd(CFD_ADDR_ID_HIGH, TB_PART[10:3]);
        rd(22'h300000, 8'h00);
        rd(22'h300004, 8'h00);
        for (int n = 0; n < 16; n++)
        begin
            i = n[3:0];
            img.clk_src = {i[1], i[0], 2'b11, i};
            img.bor_powerup_delay_timer = {3'b111, i[3:2], i[1:0], i[2]};
            img.wdt = {3'b111, i, i[0]};
            img.pin_tmr = {i[0], 4'hF, i[1], 1'b1, i[2]};
            img.dbg = {i[0], i[1], 5'h1F, i[3]};
            img.cp = {7'h7F, i[1]};
            load(img);
            check_ctrl(i, 1'b0, 1'b0);
            @(posedge core_clk);
            sleep_mode <= 1'b1;
            sw_brownout_en <= 1'b1;
            sw_watchdog_en <= 1'b1;
            tick(1);
            check_ctrl(i, 1'b1, 1'b1);
            for (int k = 0; k < 6; k++)
                rd(addr_tab[k], img[47-8*k -: 8] & mask_tab[k]);
        end
        // last image leaves code protection off
        wr(CFD_ADDR_CP, 8'h01);
        wr(CFD_ADDR_CLK_SRC, 8'h00);
        tick(1);
        `cfd_chk(ctrl.code_protected, 1'b0)
        rd(CFD_ADDR_CLK_SRC, 8'hCF);
        wr(CFD_ADDR_CP, 8'hFE);
        tick(1);
        `cfd_chk(ctrl.code_protected, 1'b1)
        rd(CFD_ADDR_CP, 8'h00);
        wr(CFD_ADDR_CP, 8'h01);
        tick(2);
        `cfd_chk(ctrl.code_protected, 1'b1)
        rd(CFD_ADDR_CP, 8'h00);
        close_out();
    end

    initial
    begin
        #200000;
        n_fail++;
        close_out();
    end

endmodule
